// ==== core/usb_ep_dma_iso.sv ====
// Endpoint DMA channel, bank validation, isochronous IN answers, OUT banks
// Assumes synchronous inputs, a memory port answering with mem_ack,
// and an endpoint RAM with combinational read at ept_addr
// Operation
// - DMA copies memory and endpoint RAM, not control
// - End-of-buffer interrupt when count reaches zero
// - Buffer end validates per auto-valid, short-packet
// - Channel runs, halts itself at buffer end
// - Auto-valid validates IN, releases OUT banks
// - Load-next fetches aligned descriptor from pointer
// - Update status at buffer end, then fetch chained descriptor
// - Enabled endpoint interrupt halts DMA if chosen
// - First status stage token answered with NAK
// - Iso IN without bank, one transaction per microframe: silence, underflow flag
// - First token sends matching PID; leftovers flushed
// - No bank at first token: DATA0 ZLP
// - Second of three unready: DATA1 ZLP
// - Last transaction unready: DATA0 ZLP, underflow flag
// - No token in microframe: no flush, no error
// - Data sent, fewer validated than programmed: transaction error
// - Received bank flag with count, software clears
// - Auto-valid zero-length OUT clears flag itself
// - Busy-bank interrupt when all banks filled
module usb_ep_dma_iso
  import usb_ep_dma_pkg::*;
(
  input  wire logic              clk_sys,
  input  wire logic              rst,
  input  wire logic              ctrl_write,
  input  wire logic              channel_run_enable,
  input  wire logic              load_next_descriptor,
  input  wire logic              end_buffer_irq_en,
  input  wire logic              buffer_done_notify_en,
  input  wire logic              irq_halts_dma,
  input  wire logic              short_packet_option,
  input  wire logic              auto_valid,
  input  wire logic              dir_in,
  input  wire logic              is_control,
  input  wire logic [LEN_W-1:0]  buf_len,
  input  wire logic [ADDR_W-1:0] dma_buffer_address,
  input  wire logic [ADDR_W-1:0] dma_next_descriptor_ptr,
  input  wire logic              ep_irq_event,
  output logic                   dma_busy,
  output logic [LEN_W-1:0]       dma_buf_count,
  output logic                   dma_end_buf_irq,
  output logic                   dma_buffer_done,
  output logic                   mem_req,
  output logic                   mem_we,
  output logic [ADDR_W-1:0]      mem_addr,
  output logic [DATA_W-1:0]      mem_wdata,
  input  wire logic              mem_ack,
  input  wire logic [DATA_W-1:0] mem_rdata,
  output logic                   ept_we,
  output logic [EPT_AW-1:0]      ept_addr,
  output logic [DATA_W-1:0]      ept_wdata,
  input  wire logic [DATA_W-1:0] ept_rdata,
  input  wire logic              iso_mode,
  input  wire logic [1:0]        transactions_per_microframe,
  input  wire logic              tx_packet_ready_set,
  input  wire logic              microframe_end,
  input  wire logic              in_token,
  output logic                   tx_packet_ready,
  output logic                   tx_resp_valid,
  output logic                   tx_resp_zlp,
  output pid_t                   tx_resp_pid,
  input  wire logic [2:0]        err_clear,
  output logic                   iso_underflow_error,
  output logic                   bank_flush_error,
  output logic                   transaction_count_error,
  input  wire logic              out_packet_rx,
  input  wire logic [BLEN_W-1:0] out_packet_bytes,
  input  wire logic              rx_bank_clear,
  output logic                   rx_bank_ready,
  output logic [BLEN_W-1:0]      rx_byte_count,
  output logic                   busy_bank_irq,
  input  wire logic              status_stage_begin,
  input  wire logic              status_token,
  output logic                   status_nak
);
  dma_state_t        state_q;
  logic [1:0]        idx_q, bank_q, tx_banks_q, rx_banks_q, rx_wr_q, rx_rd_q;
  logic [1:0]        tok_q, val_uf_q;
  logic [ADDR_W-1:0] dsc_q, cur_q, nxt_q;
  logic [LEN_W-1:0]  cnt_q;
  logic [7:0]        word_q;
  logic              ldnxt_q, endb_q, ebit_q;
  logic              tx_val_q, rx_rel_q, sent_q, first_zlp_q, status_first_q;
  logic [BLEN_W-1:0] rx_len_q [3];
  logic              can_go, last_word, buf_end, halt, has_bank;
  logic [7:0]        head_words;
  logic [EPT_AW-1:0] want_addr;

  assign dma_busy        = state_q != DMA_IDLE;
  assign dma_buf_count   = cnt_q;
  assign tx_packet_ready = tx_banks_q != 2'h0;
  assign rx_bank_ready   = rx_banks_q != 2'h0;
  assign rx_byte_count   = rx_len_q[rx_rd_q];
  assign head_words      = 8'((rx_byte_count + 11'h003) >> 2);
  assign last_word       = word_q == BANK_WORDS - 8'h01;
  assign buf_end         = cnt_q == 16'h0001;
  assign has_bank        = tx_banks_q != 2'h0;
  assign halt            = ep_irq_event && irq_halts_dma && dma_busy;
  assign can_go          = dir_in ? (tx_banks_q < NB_BANKS) : rx_bank_ready;
  assign want_addr       = {dir_in ? bank_q : rx_rd_q, word_q};

  // Channel sequencing, descriptor fetch and word moves
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      state_q         <= DMA_IDLE;
      idx_q           <= 2'h0;
      dsc_q           <= '0;
      nxt_q           <= '0;
      cur_q           <= '0;
      cnt_q           <= LEN_RST;
      word_q          <= 8'h00;
      bank_q          <= 2'h0;
      ldnxt_q         <= 1'b0;
      endb_q          <= 1'b0;
      ebit_q          <= 1'b0;
      mem_req         <= 1'b0;
      mem_we          <= 1'b0;
      mem_addr        <= '0;
      mem_wdata       <= '0;
      ept_we          <= 1'b0;
      ept_addr        <= '0;
      ept_wdata       <= '0;
      tx_val_q        <= 1'b0;
      rx_rel_q        <= 1'b0;
      dma_end_buf_irq <= 1'b0;
      dma_buffer_done <= 1'b0;
    end else begin
      ept_we          <= 1'b0;
      tx_val_q        <= 1'b0;
      rx_rel_q        <= 1'b0;
      dma_end_buf_irq <= 1'b0;
      if (halt) begin
        state_q <= DMA_IDLE;
        mem_req <= 1'b0;
      end else begin
        unique case (state_q)
          DMA_IDLE: begin
            if (ctrl_write) begin
              ldnxt_q         <= load_next_descriptor;
              endb_q          <= buffer_done_notify_en;
              ebit_q          <= end_buffer_irq_en;
              dma_buffer_done <= 1'b0;
              word_q          <= 8'h00;
              if (load_next_descriptor) begin
                dsc_q   <= dma_next_descriptor_ptr & DSC_ALIGN_MASK;
                idx_q   <= 2'h0;
                state_q <= DMA_FETCH;
              end else if (channel_run_enable && !is_control && buf_len != LEN_RST) begin
                cur_q   <= dma_buffer_address;
                cnt_q   <= buf_len;
                state_q <= DMA_XFER;
              end
            end
          end
          DMA_FETCH: begin
            if (!mem_req) begin
              mem_req  <= 1'b1;
              mem_we   <= 1'b0;
              mem_addr <= dsc_q + {28'h0, idx_q, 2'h0};
            end else if (mem_ack) begin
              mem_req <= 1'b0;
              idx_q   <= idx_q + 2'h1;
              unique case (idx_q)
                2'h0:    nxt_q <= mem_rdata & DSC_ALIGN_MASK;
                2'h1:    cur_q <= mem_rdata;
                default: begin
                  ldnxt_q <= mem_rdata[DSC_LDNXT_BIT];
                  endb_q  <= mem_rdata[DSC_ENDB_BIT];
                  ebit_q  <= mem_rdata[DSC_EBIT_BIT];
                  cnt_q   <= mem_rdata[DSC_LEN_LSB +: LEN_W];
                end
              endcase
              if (idx_q == DSC_LAST) begin
                state_q <= (mem_rdata[DSC_RUN_BIT] && !is_control
                            && mem_rdata[DSC_LEN_LSB +: LEN_W] != LEN_RST)
                           ? DMA_XFER : DMA_IDLE;
              end
            end
          end
          DMA_XFER: begin
            if (!mem_req && !ept_we) begin
              ept_addr <= want_addr;
              if (can_go && ept_addr == want_addr) begin
                mem_req   <= 1'b1;
                mem_we    <= !dir_in;
                mem_addr  <= cur_q;
                mem_wdata <= ept_rdata;
              end
            end else if (mem_req && mem_ack) begin
              mem_req <= 1'b0;
              cur_q   <= cur_q + WORD_STEP;
              cnt_q   <= cnt_q - 16'h0001;
              if (dir_in) begin
                ept_we    <= 1'b1;
                ept_wdata <= mem_rdata;
                if (auto_valid && (last_word
                    || (buf_end && endb_q && short_packet_option))) begin
                  tx_val_q <= 1'b1;
                  bank_q   <= (bank_q == NB_BANKS - 2'h1) ? 2'h0 : bank_q + 2'h1;
                  word_q   <= 8'h00;
                end else begin
                  word_q <= word_q + 8'h01;
                end
              end else if (auto_valid && (word_q + 8'h01 >= head_words
                           || (buf_end && endb_q))) begin
                rx_rel_q <= 1'b1;
                word_q   <= 8'h00;
              end else begin
                word_q <= word_q + 8'h01;
              end
              if (buf_end) begin
                dma_end_buf_irq <= ebit_q;
                dma_buffer_done <= 1'b1;
                idx_q           <= 2'h0;
                dsc_q           <= nxt_q;
                state_q         <= ldnxt_q ? DMA_FETCH : DMA_IDLE;
              end
            end
          end
        endcase
      end
    end
  end

  // Transmit banks and isochronous answers per microframe
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      tx_banks_q              <= 2'h0;
      tok_q                   <= 2'h0;
      val_uf_q                <= 2'h0;
      sent_q                  <= 1'b0;
      first_zlp_q             <= 1'b0;
      tx_resp_valid           <= 1'b0;
      tx_resp_zlp             <= 1'b0;
      tx_resp_pid             <= PID_DATA0;
      iso_underflow_error     <= 1'b0;
      bank_flush_error        <= 1'b0;
      transaction_count_error <= 1'b0;
    end else begin
      logic       inc, dec, uf, fl, te;
      inc = (tx_val_q || tx_packet_ready_set) && tx_banks_q < NB_BANKS;
      dec = 1'b0;
      uf  = 1'b0;
      fl  = 1'b0;
      te  = 1'b0;
      tx_resp_valid <= 1'b0;
      if (inc && val_uf_q != 2'h3) val_uf_q <= val_uf_q + 2'h1;
      if (in_token) begin
        if (tok_q != 2'h3) tok_q <= tok_q + 2'h1;
        if (has_bank) begin
          dec = 1'b1;
          sent_q        <= 1'b1;
          tx_resp_valid <= 1'b1;
          tx_resp_zlp   <= 1'b0;
          tx_resp_pid   <= iso_mode ? pid_t'(transactions_per_microframe - 2'h1 - tok_q)
                                    : PID_DATA0;
        end else if (iso_mode) begin
          uf = 1'b1;
          if (transactions_per_microframe > 2'h1) begin
            tx_resp_valid <= 1'b1;
            tx_resp_zlp   <= 1'b1;
            tx_resp_pid   <= (tok_q == 2'h1 && transactions_per_microframe == 2'h3)
                             ? PID_DATA1 : PID_DATA0;
            if (tok_q == 2'h0) first_zlp_q <= 1'b1;
          end
        end
      end
      if (microframe_end && iso_mode) begin
        if (tok_q != 2'h0 && has_bank && !(first_zlp_q && !sent_q)) begin
          fl = 1'b1;
        end
        te = sent_q && val_uf_q < transactions_per_microframe;
        tok_q       <= 2'h0;
        val_uf_q    <= 2'h0;
        sent_q      <= 1'b0;
        first_zlp_q <= 1'b0;
      end
      tx_banks_q <= fl ? 2'h0 : tx_banks_q + {1'b0, inc} - {1'b0, dec};
      iso_underflow_error     <= (iso_underflow_error && !err_clear[0]) || uf;
      bank_flush_error        <= (bank_flush_error && !err_clear[1]) || fl;
      transaction_count_error <= (transaction_count_error && !err_clear[2]) || te;
    end
  end

  // Received banks for OUT transfers
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      rx_banks_q    <= 2'h0;
      rx_wr_q       <= 2'h0;
      rx_rd_q       <= 2'h0;
      busy_bank_irq <= 1'b0;
      rx_len_q      <= '{default: '0};
    end else begin
      logic fill, rel;
      fill = out_packet_rx && rx_banks_q < NB_BANKS
             && !(auto_valid && out_packet_bytes == '0);
      rel  = (rx_bank_clear || rx_rel_q) && rx_bank_ready;
      busy_bank_irq <= fill && !rel && rx_banks_q == NB_BANKS - 2'h1;
      if (fill) begin
        rx_len_q[rx_wr_q] <= out_packet_bytes;
        rx_wr_q <= (rx_wr_q == NB_BANKS - 2'h1) ? 2'h0 : rx_wr_q + 2'h1;
      end
      if (rel) rx_rd_q <= (rx_rd_q == NB_BANKS - 2'h1) ? 2'h0 : rx_rd_q + 2'h1;
      rx_banks_q <= rx_banks_q + {1'b0, fill} - {1'b0, rel};
    end
  end

  // Status stage handshake
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      status_first_q <= 1'b0;
      status_nak     <= 1'b0;
    end else begin
      status_nak <= status_token && status_first_q;
      if (status_stage_begin) status_first_q <= 1'b1;
      else if (status_token) status_first_q <= 1'b0;
    end
  end

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  halt_on_irq_a: assert property (halt |=> !dma_busy && !mem_req)
    else $error("DMA kept running after endpoint interrupt");
  end_buf_irq_a: assert property (dma_end_buf_irq |-> cnt_q == LEN_RST && ebit_q)
    else $error("End-of-buffer interrupt with count not zero");
  stop_at_end_a: assert property (state_q == DMA_XFER && mem_req && mem_ack && buf_end
    && !ldnxt_q && !halt |=> state_q == DMA_IDLE && dma_buffer_done)
    else $error("Channel did not stop at buffer end");
  iso_silent_a: assert property (in_token && iso_mode && !has_bank
    && transactions_per_microframe == 2'h1 |=> !tx_resp_valid && iso_underflow_error)
    else $error("Iso IN answered without a bank");
  first_zlp_a: assert property (in_token && iso_mode && !has_bank && tok_q == 2'h0
    && transactions_per_microframe > 2'h1
    |=> tx_resp_valid && tx_resp_zlp && tx_resp_pid == PID_DATA0)
    else $error("First unready token not answered with DATA0 ZLP");
  second_zlp_a: assert property (in_token && iso_mode && !has_bank && tok_q == 2'h1
    && transactions_per_microframe == 2'h3 |=> tx_resp_zlp && tx_resp_pid == PID_DATA1)
    else $error("Second unready token not answered with DATA1 ZLP");
  first_pid_a: assert property (in_token && iso_mode && has_bank && tok_q == 2'h0
    |=> tx_resp_pid == pid_t'($past(transactions_per_microframe) - 2'h1))
    else $error("Wrong PID on first iso token");
  no_token_a: assert property (microframe_end && iso_mode && tok_q == 2'h0
    && !bank_flush_error && !transaction_count_error
    |=> !bank_flush_error && !transaction_count_error)
    else $error("Error flagged in microframe without token");
  busy_bank_a: assert property (busy_bank_irq |-> rx_banks_q == NB_BANKS)
    else $error("Busy-bank interrupt with a free bank");
  status_nak_a: assert property (status_token |=> status_nak == $past(status_first_q))
    else $error("Status stage NAK not limited to first token");

  iso_send_c: cover property (in_token && iso_mode && has_bank ##[1:40] microframe_end);
  flush_c:    cover property (microframe_end && iso_mode && has_bank && tok_q != 2'h0);
  chain_c:    cover property (state_q == DMA_XFER && buf_end && mem_ack && ldnxt_q);
endmodule // usb_ep_dma_iso

// ==== pkg/usb_ep_dma_pkg.sv ====
// Constants and types for the endpoint DMA and isochronous IN engine
// Assumes one endpoint with word-wide endpoint RAM and a word memory port
package usb_ep_dma_pkg;
  localparam int ADDR_W = 32;
  localparam int DATA_W = 32;
  localparam int LEN_W  = 16;
  localparam int EPT_AW = 10;
  localparam int BLEN_W = 11;
  // Banks per endpoint and words per bank
  localparam logic [1:0] NB_BANKS   = 2'h3;
  localparam logic [7:0] BANK_WORDS = 8'h80;
  // Descriptor: word 0 next pointer, word 1 buffer address, word 2 control
  localparam logic [1:0] DSC_LAST     = 2'h2;
  localparam int         DSC_RUN_BIT  = 0;
  localparam int         DSC_LDNXT_BIT = 1;
  localparam int         DSC_ENDB_BIT = 2;
  localparam int         DSC_EBIT_BIT = 3;
  localparam int         DSC_LEN_LSB  = 16;
  localparam logic [ADDR_W-1:0] DSC_ALIGN_MASK = 32'hffff_fff0;
  localparam logic [ADDR_W-1:0] WORD_STEP      = 32'h0000_0004;
  localparam logic [LEN_W-1:0]  LEN_RST        = 16'h0000;
  typedef enum {DMA_IDLE, DMA_FETCH, DMA_XFER} dma_state_t;
  typedef enum logic [1:0] {
    PID_DATA0 = 2'h0,
    PID_DATA1 = 2'h1,
    PID_DATA2 = 2'h2,
    PID_MDATA = 2'h3
  } pid_t;
endpackage

// ==== verification/usb_mem_model.sv ====
// System memory and endpoint RAM model facing the DMA channel
// Assumes requests are held until mem_ack; answers alternate prompt and slow
module usb_mem_model
  import usb_ep_dma_pkg::*;
(
  input  wire logic              clk_sys,
  input  wire logic              mem_req,
  input  wire logic              mem_we,
  input  wire logic [ADDR_W-1:0] mem_addr,
  input  wire logic [DATA_W-1:0] mem_wdata,
  output logic                   mem_ack,
  output logic [DATA_W-1:0]      mem_rdata,
  input  wire logic              ept_we,
  input  wire logic [EPT_AW-1:0] ept_addr,
  input  wire logic [DATA_W-1:0] ept_wdata,
  output logic [DATA_W-1:0]      ept_rdata
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [DATA_W-1:0] mem [0:255];
  logic [DATA_W-1:0] ept [0:1023];
  int                wait_n = 0;
  bit                slow = 1'b0;
  initial mem_ack = 1'b0;
  initial mem_rdata = 32'h0;
  assign ept_rdata = ept[ept_addr];
  always @(posedge clk_sys) begin
    mem_ack <= 1'b0;
    // Data lines not driven: toggle
    mem_rdata <= ~mem_rdata;
    if (ept_we) begin
      ept[ept_addr] <= ept_wdata;
    end
    if (mem_req && !mem_ack) begin
      if (wait_n == (slow ? 3 : 0)) begin
        mem_ack <= 1'b1;
        mem_rdata <= mem[mem_addr[9:2]];
        if (mem_we) begin
          mem[mem_addr[9:2]] <= mem_wdata;
        end
        wait_n <= 0;
        slow <= !slow;
      end else begin
        wait_n <= wait_n + 1;
      end
    end
  end
endmodule // usb_mem_model

// ==== verification/tb_top.sv ====
// Self-checking bench for the endpoint DMA and isochronous IN engine
// Assumes usb_mem_model answers the memory port and holds endpoint RAM
module tb_top;
  import usb_ep_dma_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_sys, rst = 1'b1, ctrl_write = 0, channel_run_enable = 0, load_next_descriptor = 0;
  logic end_buffer_irq_en = 0, buffer_done_notify_en = 0, irq_halts_dma = 0, is_control = 0;
  logic short_packet_option = 0, auto_valid = 0, dir_in = 0, ep_irq_event = 0, iso_mode = 0;
  logic tx_packet_ready_set = 0, microframe_end = 0, in_token = 0, out_packet_rx = 0;
  logic rx_bank_clear = 0, status_stage_begin = 0, status_token = 0, mem_ack;
  logic [1:0]        transactions_per_microframe = 2'h1;
  logic [2:0]        err_clear = 3'h0;
  logic [LEN_W-1:0]  buf_len = 16'h0, dma_buf_count;
  logic [ADDR_W-1:0] dma_buffer_address = 32'h0, dma_next_descriptor_ptr = 32'h0, mem_addr;
  logic [DATA_W-1:0] mem_rdata, mem_wdata, ept_wdata, ept_rdata;
  logic [BLEN_W-1:0] out_packet_bytes = 11'h0, rx_byte_count;
  logic [EPT_AW-1:0] ept_addr;
  logic dma_busy, dma_end_buf_irq, dma_buffer_done, mem_req, mem_we, ept_we, tx_packet_ready;
  logic tx_resp_valid, tx_resp_zlp, iso_underflow_error, bank_flush_error, status_nak;
  logic transaction_count_error, rx_bank_ready, busy_bank_irq;
  pid_t tx_resp_pid;
  int   bad_count = 0, samples_checked = 0, n_irq = 0, n_busy = 0, n_nak = 0, k;
  logic rv, zlp;
  logic [1:0] pid;
  typedef struct packed {
    logic [1:0] nb, nv, nt;
    logic rv, zlp;
    logic [1:0] pid;
    logic un, fl, tr;
  } iso_row_t;
  iso_row_t r;
  iso_row_t rows [9] = '{
    '{2'h1, 2'h0, 2'h1, 1'b0, 1'b0, 2'h0, 1'b1, 1'b0, 1'b0},
    '{2'h1, 2'h1, 2'h1, 1'b1, 1'b0, 2'h0, 1'b0, 1'b0, 1'b0},
    '{2'h3, 2'h0, 2'h1, 1'b1, 1'b1, 2'h0, 1'b1, 1'b0, 1'b0},
    '{2'h3, 2'h1, 2'h1, 1'b1, 1'b0, 2'h2, 1'b0, 1'b0, 1'b1},
    '{2'h3, 2'h1, 2'h2, 1'b1, 1'b1, 2'h1, 1'b1, 1'b0, 1'b1},
    '{2'h2, 2'h1, 2'h2, 1'b1, 1'b1, 2'h0, 1'b1, 1'b0, 1'b1},
    '{2'h2, 2'h2, 2'h2, 1'b1, 1'b0, 2'h0, 1'b0, 1'b0, 1'b0},
    '{2'h2, 2'h1, 2'h0, 1'b0, 1'b0, 2'h0, 1'b0, 1'b0, 1'b0},
    '{2'h3, 2'h2, 2'h1, 1'b1, 1'b0, 2'h2, 1'b0, 1'b1, 1'b1}
  };
  usb_ep_dma_iso u_dut (.clk_sys, .rst, .ctrl_write, .channel_run_enable, .load_next_descriptor,
    .end_buffer_irq_en, .buffer_done_notify_en, .irq_halts_dma, .short_packet_option,
    .auto_valid, .dir_in, .is_control, .buf_len, .dma_buffer_address, .dma_next_descriptor_ptr,
    .ep_irq_event, .dma_busy, .dma_buf_count, .dma_end_buf_irq, .dma_buffer_done, .mem_req,
    .mem_we, .mem_addr, .mem_wdata, .mem_ack, .mem_rdata, .ept_we, .ept_addr, .ept_wdata,
    .ept_rdata, .iso_mode, .transactions_per_microframe, .tx_packet_ready_set, .microframe_end,
    .in_token, .tx_packet_ready, .tx_resp_valid, .tx_resp_zlp, .tx_resp_pid, .err_clear,
    .iso_underflow_error, .bank_flush_error, .transaction_count_error, .out_packet_rx,
    .out_packet_bytes, .rx_bank_clear, .rx_bank_ready, .rx_byte_count, .busy_bank_irq,
    .status_stage_begin, .status_token, .status_nak);
  usb_mem_model u_mem (.clk_sys, .mem_req, .mem_we, .mem_addr, .mem_wdata, .mem_ack,
    .mem_rdata, .ept_we, .ept_addr, .ept_wdata, .ept_rdata);
  initial begin
    clk_sys = 1'b0;
    forever #20 clk_sys = ~clk_sys;
  end
  // Pulse counters
  always @(posedge clk_sys) begin
    if (dma_end_buf_irq === 1'b1) n_irq++;
    if (busy_bank_irq === 1'b1) n_busy++;
    if (status_nak === 1'b1) n_nak++;
  end
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      bad_count++;
      $display("MISMATCH %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic tick(input int n = 1);
    repeat (n) @(posedge clk_sys);
  endtask
  task automatic do_reset();
    rst <= 1'b1;
    tick(2);
    rst <= 1'b0;
    tick();
  endtask
  task automatic start();
    ctrl_write <= 1'b1;
    tick();
    ctrl_write <= 1'b0;
    #1;
  endtask
  task automatic wait_idle();
    int n;
    n = 0;
    do begin
      @(posedge clk_sys);
      #1;
      n++;
    end while (dma_busy !== 1'b0 && n < 2000);
  endtask
  task automatic rx_pkt();
    out_packet_rx <= 1'b1;
    tick();
    out_packet_rx <= 1'b0;
    tick();
  endtask
  task automatic summarize();
    $display("comparisons %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  initial begin
    #(40 * 60000);
    bad_count++;
    summarize();
  end
  initial begin
    foreach (rows[i]) begin
      r = rows[i];
      do_reset();
      iso_mode <= 1'b1;
      transactions_per_microframe <= r.nb;
      repeat (r.nv) begin
        tx_packet_ready_set <= 1'b1;
        tick();
        tx_packet_ready_set <= 1'b0;
        tick();
      end
      tick(2);
      #1;
      chk("tx_packet_ready", {31'h0, r.nv != 2'h0}, {31'h0, tx_packet_ready});
      {rv, zlp, pid} = 4'h0;
      repeat (r.nt) begin
        @(posedge clk_sys);
        in_token <= 1'b1;
        tick();
        in_token <= 1'b0;
        #1;
        {rv, zlp, pid} = {tx_resp_valid, tx_resp_zlp, tx_resp_pid};
        tick(3);
      end
      @(posedge clk_sys);
      microframe_end <= 1'b1;
      tick();
      microframe_end <= 1'b0;
      tick(2);
      #1;
      chk("resp", {29'h0, r.rv, r.zlp, r.pid}, {29'h0, rv, zlp, pid});
      chk("underflow", {31'h0, r.un}, {31'h0, iso_underflow_error});
      chk("flush", {31'h0, r.fl}, {31'h0, bank_flush_error});
      chk("trans", {31'h0, r.tr}, {31'h0, transaction_count_error});
    end
    err_clear <= 3'h7;
    tick();
    err_clear <= 3'h0;
    tick();
    #1;
    chk("flags cleared", 32'h0, {29'h0, iso_underflow_error, bank_flush_error,
        transaction_count_error});
    do_reset();
    u_mem.mem[8'h40] = 32'h1234_5678;
    u_mem.mem[8'h41] = 32'h9abc_def0;
    dir_in <= 1'b1;
    auto_valid <= 1'b1;
    buffer_done_notify_en <= 1'b1;
    short_packet_option <= 1'b1;
    end_buffer_irq_en <= 1'b1;
    is_control <= 1'b1;
    channel_run_enable <= 1'b1;
    buf_len <= 16'h0002;
    dma_buffer_address <= 32'h0000_0100;
    tick();
    start();
    tick();
    #1;
    chk("control refused", 32'h0, {31'h0, dma_busy});
    is_control <= 1'b0;
    k = n_irq;
    tick();
    start();
    chk("dma_busy", 32'h1, {31'h0, dma_busy});
    wait_idle();
    chk("dma idle", 32'h0, {31'h0, dma_busy});
    chk("dma_buf_count", 32'h0, {16'h0, dma_buf_count});
    chk("dma_buffer_done", 32'h1, {31'h0, dma_buffer_done});
    tick(3);
    #1;
    chk("end irq count", k + 1, n_irq);
    chk("ept word0", 32'h1234_5678, u_mem.ept[0]);
    chk("ept word1", 32'h9abc_def0, u_mem.ept[1]);
    chk("auto validated", 32'h1, {31'h0, tx_packet_ready});
    // Two chained descriptors: last one has load-next 0 and run 1
    u_mem.mem[8'h80] = 32'h0000_0210;
    u_mem.mem[8'h81] = 32'h0000_0140;
    u_mem.mem[8'h82] = 32'h0001_000b;
    u_mem.mem[8'h84] = 32'h0;
    u_mem.mem[8'h85] = 32'h0000_0144;
    u_mem.mem[8'h86] = 32'h0001_0009;
    u_mem.mem[8'h50] = 32'h0bad_cafe;
    u_mem.mem[8'h51] = 32'h0000_beef;
    end_buffer_irq_en <= 1'b0;
    channel_run_enable <= 1'b0;
    load_next_descriptor <= 1'b1;
    dma_next_descriptor_ptr <= 32'h0000_0205;
    k = n_irq;
    tick();
    start();
    wait_idle();
    load_next_descriptor <= 1'b0;
    chk("dsc count", 32'h0, {16'h0, dma_buf_count});
    chk("dsc done", 32'h1, {31'h0, dma_buffer_done});
    tick(3);
    #1;
    chk("dsc irq count", k + 2, n_irq);
    chk("dsc word0", 32'h0bad_cafe, u_mem.ept[10'h100]);
    chk("chained word", 32'h0000_beef, u_mem.ept[10'h101]);
    channel_run_enable <= 1'b1;
    irq_halts_dma <= 1'b1;
    buf_len <= 16'h0004;
    dma_buffer_address <= 32'h0000_0180;
    tick();
    start();
    tick();
    ep_irq_event <= 1'b1;
    tick();
    ep_irq_event <= 1'b0;
    tick();
    #1;
    chk("halt busy", 32'h0, {31'h0, dma_busy});
    chk("halt mem_req", 32'h0, {31'h0, mem_req});
    do_reset();
    auto_valid <= 1'b0;
    out_packet_bytes <= 11'h00c;
    rx_pkt();
    #1;
    chk("rx_bank_ready", 32'h1, {31'h0, rx_bank_ready});
    chk("rx_byte_count", 32'h0000_000c, {21'h0, rx_byte_count});
    k = n_busy;
    rx_pkt();
    rx_pkt();
    tick(2);
    #1;
    chk("busy bank irq", k + 1, n_busy);
    repeat (3) begin
      rx_bank_clear <= 1'b1;
      tick();
      rx_bank_clear <= 1'b0;
      tick();
    end
    #1;
    chk("rx released", 32'h0, {31'h0, rx_bank_ready});
    auto_valid <= 1'b1;
    out_packet_bytes <= 11'h000;
    rx_pkt();
    tick();
    #1;
    chk("zlp flag", 32'h0, {31'h0, rx_bank_ready});
    out_packet_bytes <= 11'h008;
    rx_pkt();
    dir_in <= 1'b0;
    buf_len <= 16'h0002;
    dma_buffer_address <= 32'h0000_0300;
    tick();
    start();
    wait_idle();
    tick();
    #1;
    chk("out word1", 32'h9abc_def0, u_mem.mem[8'hc1]);
    chk("out released", 32'h0, {31'h0, rx_bank_ready});
    k = n_nak;
    status_stage_begin <= 1'b1;
    tick();
    status_stage_begin <= 1'b0;
    tick();
    repeat (2) begin
      status_token <= 1'b1;
      tick();
      status_token <= 1'b0;
      tick(3);
    end
    chk("status nak count", k + 1, n_nak);
    summarize();
  end
endmodule // tb_top
